// ===== rtl/fawu_pkg.sv
package fawu_pkg;
  // Register offsets on the register port
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h01;
  localparam logic [7:0] ADDR_WDOG_CFG = 8'h03;
  localparam logic [7:0] ADDR_FLAGS = 8'h0B;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_RESPONSE = 8'h0D;
  localparam logic [7:0] ADDR_CODE = 8'h0E;
  // Write address byte that services the watchdog
  localparam logic [7:0] WDOG_KICK_ADDR = 8'h10;
  // Widths
  localparam int REG_W = 16;
  localparam int CODE_W = 6;
  localparam int NCH = 4;
  localparam int NMON = 12;
  // Flag bit positions (mask uses the same layout)
  localparam int FLG_CH = 0;
  localparam int FLG_OT = 4;
  localparam int FLG_CRC = 5;
  localparam int FLG_WDT = 6;
  localparam int FLG_PG = 8;
  localparam int FLG_ALD = 12;
  localparam logic [15:0] FLG_STICKY = 16'h007F;
  // Watchdog config bits
  localparam int CFG_WEN = 0;
  localparam int CFG_WPD = 1;
  localparam int CFG_CRC_EN = 3;
  localparam int CFG_SAT_ONLY = 4;
  localparam int CFG_VOUT_HIZ = 5;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // Response select fields, two bits each
  localparam int RSP_OC = 0;
  localparam int RSP_OT = 2;
  localparam int RSP_OUTF = 4;
  localparam int RSP_COMM = 6;
  localparam logic [1:0] RSP_NONE = 2'h0;
  localparam logic [1:0] RSP_LOAD_CODE = 2'h1;
  localparam logic [1:0] RSP_SHUTDOWN = 2'h2;
  localparam logic [1:0] CLAMP_TRACK = 2'h0;
  // Synchronised input vector layout
  localparam int IN_OC = 0;
  localparam int IN_COMP = 4;
  localparam int IN_SAT = 8;
  localparam int IN_SHORT = 12;
  localparam int IN_MAXV = 16;
  localparam int IN_OT = 20;
  localparam int IN_POS_OK = 21;
  localparam int IN_NEG_OK = 25;
  localparam int IN_ALD = 29;
  localparam int IN_W = 30;
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int PERSIST_US = 500;
  localparam int CLEAR_US = 8;
  localparam int PERSIST_CYC = PERSIST_US * CLK_MHZ;
  localparam int CLEAR_CYC = CLEAR_US * CLK_MHZ;
  localparam int WDOG_MS0 = 10;
  localparam int WDOG_MS1 = 50;
  localparam int WDOG_MS2 = 100;
  localparam int WDOG_MS3 = 200;
endpackage

// ===== rtl/fawu_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// RULE_01 - Open circuit over 500 us pulls alarm low
// RULE_02 - Compliance headroom lost over 500 us alarms
// RULE_03 - Option: compliance alarm only once converter saturated
// RULE_04 - Die over-temperature raises the alarm
// RULE_05 - Enabled watchdog timeout or frame error alarms
// RULE_06 - Voltage short over 500 us or max voltage
// RULE_07 - Alarm releases once unmasked conditions vanish
// RULE_08 - Converter-powered open circuit latches alarm low
// RULE_09 - Open-circuit action 10 shuts channel, no latch
// RULE_10 - Power-good reads one when enabled arms good
// RULE_11 - Flags stay set until written one
// RULE_12 - Any reset clears flags, taking 8 us
// RULE_13 - Cleared flag resets if condition persists
// RULE_14 - Mask register keeps flags off the pin
// RULE_15 - Response select with fixed priority order
// RULE_16 - Action 01 applies alarm code, sticks
// RULE_17 - Alarm code applied as immediate step
// RULE_18 - Watchdog enable and two-bit period select
// RULE_19 - Kick frame to 0x10 each period
// RULE_20 - Watchdog flag cleared by reset or disable
// RULE_21 - Reset leaves defaults, outputs disabled
// RULE_22 - Host resets after power-up, reads all flags
// RULE_23 - Persistence counters restart when condition drops
// RULE_24 - Full-tracking clamp mode 00 has transients
module fawu_top #(
  parameter int PERSIST_CYC = fawu_pkg::PERSIST_CYC,
  parameter int WDOG_CYC0 = fawu_pkg::WDOG_MS0 * 1000 * fawu_pkg::CLK_MHZ,
  parameter int WDOG_CYC1 = fawu_pkg::WDOG_MS1 * 1000 * fawu_pkg::CLK_MHZ,
  parameter int WDOG_CYC2 = fawu_pkg::WDOG_MS2 * 1000 * fawu_pkg::CLK_MHZ,
  parameter int WDOG_CYC3 = fawu_pkg::WDOG_MS3 * 1000 * fawu_pkg::CLK_MHZ
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic rst_n, // Async reset, hardware pin or power-on
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [15:0] reg_wdata, // Write data
  output logic [15:0] reg_rdata, // Read data, registered
  output logic reg_rvalid, // Read data valid pulse
  input wire logic frame_done, // Serial frame accepted pulse
  input wire logic [7:0] frame_addr, // Write address byte of that frame
  input wire logic frame_crc_err, // Frame check failed pulse
  input wire logic [3:0] current_out_en, // Current outputs enabled
  input wire logic [3:0] voltage_out_en, // Voltage outputs enabled
  input wire logic [3:0] conv_en, // Converter powers channel
  input wire logic [3:0] pos_arm_en, // Positive arm enabled
  input wire logic [3:0] neg_arm_en, // Negative arm enabled
  input wire logic [1:0] clamp_mode_field, // Converter clamp mode
  input wire logic [3:0] open_circuit_det, // Async: current output open
  input wire logic [3:0] compliance_low, // Async: headroom below limit
  input wire logic [3:0] conv_saturated, // Async: converter at its rail
  input wire logic [3:0] short_limit, // Async: voltage output in limit
  input wire logic [3:0] conv_at_max, // Async: converter at max voltage
  input wire logic over_temp, // Async: die above 150 C
  input wire logic [3:0] pos_rail_ok, // Async: positive arm above 4 V
  input wire logic [3:0] neg_rail_ok, // Async: negative arm below -3 V
  input wire logic autolearn_done_flag, // Async: clamp learning complete
  output logic alarm_pin_o, // Alarm pin drive level, always low
  output logic alarm_pin_oe, // Alarm pin pulled low while high
  output logic [3:0] chan_shutdown, // Converter and amplifier disable
  output logic code_override, // Outputs forced to alarm code
  output logic [5:0] alarm_code_out, // Alarm code to the converters
  output logic code_step, // Pulse: apply code now, no slew
  output logic vout_hiz, // Voltage outputs high impedance
  output logic flags_clearing // Flag clear in progress
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (PERSIST_CYC < 1 || PERSIST_CYC > 16383)
    $error("PERSIST_CYC out of counter range");
  if (WDOG_CYC0 < 2 || WDOG_CYC1 < 2 || WDOG_CYC2 < 2 || WDOG_CYC3 < 2 ||
      WDOG_CYC0 > 16777215 || WDOG_CYC1 > 16777215 ||
      WDOG_CYC2 > 16777215 || WDOG_CYC3 > 16777215)
    $error("watchdog period out of counter range");

  // Whole module state
  typedef struct packed {
    logic [fawu_pkg::IN_W-1:0] s1; // Sync first stage
    logic [fawu_pkg::IN_W-1:0] s2; // Sync second stage
    logic [fawu_pkg::NMON-1:0][13:0] pcnt; // Persistence counters
    logic [15:0] flags; // Sticky fault flags
    logic [15:0] mask; // Fault flag mask
    logic [15:0] rsp; // Response select
    logic [5:0] code; // Alarm code
    logic [15:0] wcfg; // Watchdog config
    logic [23:0] wcnt; // Watchdog counter
    logic [3:0] latch; // Latched open-circuit alarms
    logic [3:0] shut; // Channel shutdowns
    logic code_act; // Alarm code applied
    logic [5:0] dac_code; // Code driven to converters
    logic step; // Step pulse
    logic [7:0] clr_cnt; // Flag clear countdown
    logic alarm; // Alarm pin pulled low
    logic [15:0] rdata; // Read data
    logic rvalid; // Read valid
  } fawu_st_t;

  localparam fawu_st_t ST_RST = '{clr_cnt: 8'(fawu_pkg::CLEAR_CYC),
                                  wcfg: fawu_pkg::CFG_RST, default: '0};
  localparam logic [13:0] PCNT_MAX = 14'(PERSIST_CYC);

  fawu_st_t q_ff;
  fawu_st_t nxt_q;

  // Saturating persistence counter step
  function automatic logic [13:0] fawu_persist(input logic cond, input logic [13:0] c);
    if (!cond)
      fawu_persist = '0;
    else if (c == PCNT_MAX)
      fawu_persist = c;
    else
      fawu_persist = c + 14'h0001;
  endfunction

  // Watchdog period in cycles from the period field
  function automatic logic [23:0] fawu_wdog_len(input logic [1:0] sel);
    case (sel)
      2'h0: fawu_wdog_len = 24'(WDOG_CYC0);
      2'h1: fawu_wdog_len = 24'(WDOG_CYC1);
      2'h2: fawu_wdog_len = 24'(WDOG_CYC2);
      default: fawu_wdog_len = 24'(WDOG_CYC3);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational decode
  logic [3:0] oc_c, comp_c, sh_c, oc_q, comp_q, sh_q, chf, pg;
  logic [11:0] mon;
  logic sat_only, ot, wen, kick, wd_to, crc_evt, soft_rst, clearing;
  logic [15:0] set_v, clr_v, live, newf;
  logic [1:0] act;
  logic [3:0] act_ch;

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.step = 1'b0;
    nxt_q.rvalid = 1'b0;
    clearing = (q_ff.clr_cnt != 8'h00);
    soft_rst = reg_wr && (reg_addr == fawu_pkg::ADDR_SOFT_RESET);
    // In full tracking the option waits for converter saturation
    sat_only = q_ff.wcfg[fawu_pkg::CFG_SAT_ONLY] &&
               (clamp_mode_field == fawu_pkg::CLAMP_TRACK); // RULE_24
    oc_c = q_ff.s2[fawu_pkg::IN_OC +: 4] & current_out_en;
    comp_c = q_ff.s2[fawu_pkg::IN_COMP +: 4] & current_out_en &
             (q_ff.s2[fawu_pkg::IN_SAT +: 4] | {4{~sat_only}}); // RULE_03
    sh_c = q_ff.s2[fawu_pkg::IN_SHORT +: 4] & voltage_out_en;
    mon = {sh_c, comp_c, oc_c};
    // Counters restart the moment a condition drops
    for (int i = 0; i < fawu_pkg::NMON; i++)
      nxt_q.pcnt[i] = fawu_persist(mon[i], q_ff.pcnt[i]); // RULE_23
    for (int i = 0; i < fawu_pkg::NCH; i++)
    begin
      oc_q[i] = (q_ff.pcnt[i] == PCNT_MAX); // RULE_01
      comp_q[i] = (q_ff.pcnt[i + 4] == PCNT_MAX); // RULE_02
      sh_q[i] = (q_ff.pcnt[i + 8] == PCNT_MAX); // RULE_06
    end
    chf = oc_q | comp_q | sh_q | q_ff.s2[fawu_pkg::IN_MAXV +: 4]; // RULE_06
    ot = q_ff.s2[fawu_pkg::IN_OT]; // RULE_04
    // Power-good: each enabled arm must be within its limit
    pg = conv_en & (~pos_arm_en | q_ff.s2[fawu_pkg::IN_POS_OK +: 4]) &
         (~neg_arm_en | q_ff.s2[fawu_pkg::IN_NEG_OK +: 4]); // RULE_10

    // Watchdog: a frame to the kick address restarts the count
    wen = q_ff.wcfg[fawu_pkg::CFG_WEN]; // RULE_18
    kick = frame_done && (frame_addr == fawu_pkg::WDOG_KICK_ADDR);
    wd_to = 1'b0;
    if (!wen || kick)
      nxt_q.wcnt = '0; // RULE_19
    else if (q_ff.wcnt == fawu_wdog_len(q_ff.wcfg[fawu_pkg::CFG_WPD +: 2]) - 24'h000001)
    begin
      nxt_q.wcnt = '0;
      wd_to = 1'b1; // RULE_19
    end
    else
      nxt_q.wcnt = q_ff.wcnt + 24'h000001;
    crc_evt = frame_crc_err && q_ff.wcfg[fawu_pkg::CFG_CRC_EN]; // RULE_05

    // Sticky flags: set wins over the write-one clear
    set_v = '0;
    set_v[fawu_pkg::FLG_CH +: 4] = chf;
    set_v[fawu_pkg::FLG_OT] = ot;
    set_v[fawu_pkg::FLG_CRC] = crc_evt; // RULE_05
    set_v[fawu_pkg::FLG_WDT] = wd_to; // RULE_05
    clr_v = (reg_wr && reg_addr == fawu_pkg::ADDR_FLAGS) ?
            (reg_wdata & fawu_pkg::FLG_STICKY) : 16'h0000;
    newf = set_v & ~q_ff.flags;
    if (clearing)
    begin
      // Flags held clear for the full clear time after any reset
      nxt_q.flags = '0; // RULE_12
      nxt_q.clr_cnt = q_ff.clr_cnt - 8'h01;
    end
    else
      nxt_q.flags = (q_ff.flags & ~clr_v) | set_v; // RULE_11 RULE_13
    if (!wen)
      nxt_q.flags[fawu_pkg::FLG_WDT] = 1'b0; // RULE_20

    // Open circuit on a converter-powered channel latches the pin
    for (int i = 0; i < fawu_pkg::NCH; i++)
    begin
      if (oc_q[i] && q_ff.rsp[fawu_pkg::RSP_OC +: 2] == fawu_pkg::RSP_SHUTDOWN)
        nxt_q.shut[i] = 1'b1; // RULE_09
      else if (oc_q[i] && conv_en[i] && !clearing)
        nxt_q.latch[i] = 1'b1; // RULE_08
      else if (clr_v[fawu_pkg::FLG_CH + i] || clearing)
        nxt_q.latch[i] = 1'b0; // RULE_08
    end

    // Response priority: temperature, then output, then link faults
    act = fawu_pkg::RSP_NONE;
    act_ch = '0;
    if (!clearing && newf[fawu_pkg::FLG_OT])
    begin
      act = q_ff.rsp[fawu_pkg::RSP_OT +: 2]; // RULE_15
      act_ch = 4'hF;
    end
    else if (!clearing && |newf[fawu_pkg::FLG_CH +: 4])
    begin
      act = q_ff.rsp[fawu_pkg::RSP_OUTF +: 2]; // RULE_15
      act_ch = newf[fawu_pkg::FLG_CH +: 4];
    end
    else if (!clearing && (newf[fawu_pkg::FLG_CRC] || newf[fawu_pkg::FLG_WDT]))
    begin
      act = q_ff.rsp[fawu_pkg::RSP_COMM +: 2]; // RULE_15
      act_ch = 4'hF;
    end
    if (act == fawu_pkg::RSP_LOAD_CODE)
    begin
      // Code stays applied after the fault goes away
      nxt_q.code_act = 1'b1; // RULE_16
      nxt_q.dac_code = q_ff.code; // RULE_16
      nxt_q.step = 1'b1; // RULE_17
    end
    else if (act == fawu_pkg::RSP_SHUTDOWN)
      nxt_q.shut = nxt_q.shut | act_ch;

    // Pin follows live unmasked conditions plus any latch
    live = '0;
    live[fawu_pkg::FLG_CH +: 4] = chf;
    live[fawu_pkg::FLG_OT] = ot;
    live[fawu_pkg::FLG_CRC] = q_ff.flags[fawu_pkg::FLG_CRC];
    live[fawu_pkg::FLG_WDT] = q_ff.flags[fawu_pkg::FLG_WDT];
    nxt_q.alarm = (|(live & ~q_ff.mask)) || (|q_ff.latch); // RULE_07 RULE_14

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        fawu_pkg::ADDR_WDOG_CFG: nxt_q.wcfg = reg_wdata;
        fawu_pkg::ADDR_MASK: nxt_q.mask = reg_wdata;
        fawu_pkg::ADDR_RESPONSE: nxt_q.rsp = reg_wdata;
        fawu_pkg::ADDR_CODE: nxt_q.code = reg_wdata[fawu_pkg::CODE_W-1:0];
        default: ;
      endcase
    end
    // Register reads, unmapped and write-only addresses read zero
    if (reg_rd)
    begin
      nxt_q.rvalid = 1'b1;
      case (reg_addr)
        fawu_pkg::ADDR_WDOG_CFG: nxt_q.rdata = q_ff.wcfg;
        fawu_pkg::ADDR_FLAGS:
        begin
          nxt_q.rdata = q_ff.flags;
          nxt_q.rdata[fawu_pkg::FLG_PG +: 4] = pg; // RULE_10
          nxt_q.rdata[fawu_pkg::FLG_ALD] = q_ff.s2[fawu_pkg::IN_ALD];
        end
        fawu_pkg::ADDR_MASK: nxt_q.rdata = q_ff.mask;
        fawu_pkg::ADDR_RESPONSE: nxt_q.rdata = q_ff.rsp;
        fawu_pkg::ADDR_CODE: nxt_q.rdata = {10'h000, q_ff.code};
        default: nxt_q.rdata = 16'h0000;
      endcase
    end

    // Software reset returns everything to defaults; syncs keep running
    if (soft_rst)
    begin
      nxt_q = ST_RST; // RULE_08 RULE_12 RULE_20 RULE_21
    end
    // Two-stage synchronisers shift on through a soft reset; only the
    // second stage reads the first, so a metastable value never fans out
    nxt_q.s1 = {autolearn_done_flag, neg_rail_ok, pos_rail_ok, over_temp, conv_at_max,
                short_limit, conv_saturated, compliance_low, open_circuit_det};
    nxt_q.s2 = q_ff.s1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, defaults at reset: outputs released and disabled
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= ST_RST; // RULE_21
    else
      q_ff <= nxt_q;
  end

  assign reg_rdata = q_ff.rdata;
  assign reg_rvalid = q_ff.rvalid;
  assign alarm_pin_o = 1'b0;
  assign alarm_pin_oe = q_ff.alarm;
  assign chan_shutdown = q_ff.shut;
  assign code_override = q_ff.code_act;
  assign alarm_code_out = q_ff.dac_code;
  assign code_step = q_ff.step;
  assign vout_hiz = q_ff.wcfg[fawu_pkg::CFG_VOUT_HIZ];
  assign flags_clearing = (q_ff.clr_cnt != 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_flag_sticky;
    q_ff.flags[fawu_pkg::FLG_OT] && !clearing && !soft_rst && !clr_v[fawu_pkg::FLG_OT]
      |=> q_ff.flags[fawu_pkg::FLG_OT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear"); // RULE_11

  property p_release;
    !soft_rst && q_ff.latch == 4'h0 && (live & ~q_ff.mask) == 16'h0000 |=> !alarm_pin_oe;
  endproperty
  a_release: assert property (p_release) else $error("alarm held without cause"); // RULE_07

  property p_mask_all;
    q_ff.mask == 16'hFFFF && q_ff.latch == 4'h0 |=> !alarm_pin_oe;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked fault drove pin"); // RULE_14

  property p_persist_restart;
    !mon[0] |=> q_ff.pcnt[0] == 14'h0000;
  endproperty
  a_persist_restart: assert property (p_persist_restart) else $error("counter kept"); // RULE_23

  property p_soft_clear;
    soft_rst |=> (q_ff.flags == 16'h0000 && flags_clearing) [*8];
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("flags not held clear"); // RULE_12

  property p_wdt_off;
    !wen |=> !q_ff.flags[fawu_pkg::FLG_WDT];
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog flag with watchdog off"); // RULE_20

  property p_code_stays;
    code_override && !soft_rst |=> code_override && $stable(alarm_code_out);
  endproperty
  a_code_stays: assert property (p_code_stays) else $error("alarm code dropped"); // RULE_16

  property p_oc_shut;
    oc_q[1] && !soft_rst && q_ff.rsp[fawu_pkg::RSP_OC +: 2] == fawu_pkg::RSP_SHUTDOWN
      |=> chan_shutdown[1] && !$rose(q_ff.latch[1]);
  endproperty
  a_oc_shut: assert property (p_oc_shut) else $error("open circuit shutdown missed"); // RULE_09

  property p_kick;
    kick && !soft_rst && !q_ff.flags[fawu_pkg::FLG_WDT]
      |=> q_ff.wcnt == 24'h000000 ##1 !q_ff.flags[fawu_pkg::FLG_WDT];
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not restart watchdog"); // RULE_19

  property p_crc_gate;
    frame_crc_err && !q_ff.wcfg[fawu_pkg::CFG_CRC_EN] && !q_ff.flags[fawu_pkg::FLG_CRC]
      |=> !q_ff.flags[fawu_pkg::FLG_CRC];
  endproperty
  a_crc_gate: assert property (p_crc_gate) else $error("disabled frame check flagged"); // RULE_05

endmodule
`default_nettype wire

// ===== dv/fawu_host_line.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Shared alarm line as the host sees it
module fawu_host_line (
  input wire logic alarm_pin_o, // Device drive level
  input wire logic alarm_pin_oe, // Device pulls the line
  output logic alarm_n // Wired-AND line, low = alarm
);
  // A released line rises through the pull-up
  // Other devices would join this AND, so the host must read each one
  assign alarm_n = alarm_pin_oe ? alarm_pin_o : 1'b1;
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module tb;
  logic mclk, rst_n, reg_wr, reg_rd, frame_done, frame_crc_err, over_temp, ald;
  logic [7:0] reg_addr, frame_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0] cur_en, vol_en, conv_en, pos_en, neg_en, oc, comp, sat, shrt, amax;
  logic [3:0] pos_ok, neg_ok, chan_shutdown;
  logic [1:0] clamp;
  logic [5:0] alarm_code_out;
  logic reg_rvalid, pin_o, pin_oe, code_override, code_step, vout_hiz, clearing;
  logic alarm_n; // Line level seen by the host
  int error_cnt, checks_done, n, k;
  logic [7:0] adr [7] = '{8'h01, 8'h03, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h2F};

  // Short counts keep the run brief
  fawu_top #(.PERSIST_CYC(20), .WDOG_CYC0(50), .WDOG_CYC1(60), .WDOG_CYC2(70),
    .WDOG_CYC3(80)) i_dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .frame_done(frame_done),
    .frame_addr(frame_addr), .frame_crc_err(frame_crc_err),
    .current_out_en(cur_en), .voltage_out_en(vol_en), .conv_en(conv_en),
    .pos_arm_en(pos_en), .neg_arm_en(neg_en), .clamp_mode_field(clamp),
    .open_circuit_det(oc), .compliance_low(comp), .conv_saturated(sat),
    .short_limit(shrt), .conv_at_max(amax), .over_temp(over_temp),
    .pos_rail_ok(pos_ok), .neg_rail_ok(neg_ok), .autolearn_done_flag(ald),
    .alarm_pin_o(pin_o), .alarm_pin_oe(pin_oe), .chan_shutdown(chan_shutdown),
    .code_override(code_override), .alarm_code_out(alarm_code_out),
    .code_step(code_step), .vout_hiz(vout_hiz), .flags_clearing(clearing));

  // Host side of the alarm line
  fawu_host_line i_line (.alarm_pin_o(pin_o), .alarm_pin_oe(pin_oe), .alarm_n(alarm_n));

  ////////////////////////////////////////
  // Clock, 40 ns period
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compare seen against expected, four-state
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Settle n cycles, sample 1 ns after the edge
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read strobe, data valid the following cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", {15'h0000, reg_rvalid}, 16'h0001);
    chk("read data", reg_rdata, e);
  endtask

  // Serial frame with a given write address byte, accepted or failing its check
  task automatic frame(input logic [7:0] a, input logic bad);
    @(posedge mclk);
    frame_done <= ~bad;
    frame_crc_err <= bad;
    frame_addr <= a;
    @(posedge mclk);
    frame_done <= 1'b0;
    frame_crc_err <= 1'b0;
  endtask

  // Bounded wait for the flag clear to finish; a hang ends the run
  task automatic wait_clear();
    n = 0;
    while (clearing !== 1'b0 && n < 400)
    begin
      cyc(1);
      n++;
    end
    if (n >= 400)
    begin
      chk("clear timeout", 16'h0000, 16'h0001);
      wrap_up();
    end
  endtask

  // Fault source k: open, compliance, short, max voltage, over-temp
  task automatic fault(input int f, input logic v);
    case (f)
      0: oc[0] <= v;
      1: comp[1] <= v;
      2: shrt[2] <= v;
      3: amax[3] <= v;
      default: over_temp <= v;
    endcase
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    {reg_wr, reg_rd, frame_done, frame_crc_err, over_temp, ald, reg_addr} = '0;
    {frame_addr, reg_wdata, conv_en, pos_en, neg_en, oc, comp, sat} = '0;
    {shrt, amax, pos_ok, neg_ok, clamp, error_cnt, checks_done} = '0;
    cur_en = 4'hF;
    vol_en = 4'hF;
    rst_n = 1'b0;
    cyc(10);
    rst_n <= 1'b1;
    wait_clear();
    chk("power-up clear", 16'(n >= 198 && n <= 202), 16'h0001);
    for (k = 0; k < 7; k++)
      rd(adr[k], 16'h0000);
    chk("idle line", {15'h0000, alarm_n}, 16'h0001);
    $display("reset defaults done");
    // A short open circuit restarts the persistence count
    fault(0, 1'b1);
    cyc(10);
    fault(0, 1'b0);
    cyc(30);
    rd(8'h0B, 16'h0000);
    for (k = 0; k < 5; k++)
    begin
      fault(k, 1'b1);
      cyc(30);
      rd(8'h0B, 16'h0001 << k);
      chk("line low", {15'h0000, alarm_n}, 16'h0000);
      wr(8'h0B, 16'h007F);
      cyc(3);
      rd(8'h0B, 16'h0001 << k);
      fault(k, 1'b0);
      cyc(6);
      chk("line released", {15'h0000, alarm_n}, 16'h0001);
      rd(8'h0B, 16'h0001 << k);
      wr(8'h0B, 16'h007F);
      rd(8'h0B, 16'h0000);
    end
    // Saturation-only option applies in full tracking only
    wr(8'h03, 16'h0010);
    clamp <= 2'h1;
    comp[1] <= 1'b1;
    cyc(30);
    rd(8'h0B, 16'h0002);
    clamp <= 2'h0;
    cyc(3);
    wr(8'h0B, 16'h007F);
    cyc(30);
    rd(8'h0B, 16'h0000);
    sat[1] <= 1'b1;
    cyc(30);
    rd(8'h0B, 16'h0002);
    {comp[1], sat[1]} <= 2'b00;
    $display("fault sources done");
    // Converter-powered open circuit holds the line
    conv_en <= 4'hF;
    fault(0, 1'b1);
    cyc(30);
    fault(0, 1'b0);
    cyc(10);
    chk("latched line", {15'h0000, alarm_n}, 16'h0000);
    wr(8'h0B, 16'h0001);
    cyc(3);
    chk("latch freed", {15'h0000, alarm_n}, 16'h0001);
    // Shutdown action instead of latching
    wr(8'h0D, 16'h0002);
    oc[1] <= 1'b1;
    cyc(30);
    chk("shutdown", {12'h000, chan_shutdown}, 16'h0002);
    oc[1] <= 1'b0;
    cyc(10);
    chk("no latch", {15'h0000, alarm_n}, 16'h0001);
    // Converters off again so power-good reads zero in later flag reads
    conv_en <= 4'h0;
    $display("latch and shutdown done");
    // Over-temp loads the alarm code; mask frees the line
    wr(8'h0E, 16'h002A);
    wr(8'h0D, 16'h0004);
    over_temp <= 1'b1;
    n = 0;
    while (code_step !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk("code step", {15'h0000, code_step}, 16'h0001);
    chk("override", {15'h0000, code_override}, 16'h0001);
    chk("code", {10'h000, alarm_code_out}, 16'h002A);
    wr(8'h0C, 16'hFFFF);
    cyc(3);
    chk("masked line", {15'h0000, alarm_n}, 16'h0001);
    over_temp <= 1'b0;
    wr(8'h0C, 16'h0000);
    cyc(10);
    chk("code kept", {15'h0000, code_override}, 16'h0001);
    // Software reset restores defaults and re-clears
    wr(8'h01, 16'h0000);
    cyc(1);
    chk("soft clear", {15'h0000, clearing}, 16'h0001);
    chk("soft shutdown", {12'h000, chan_shutdown}, 16'h0000);
    chk("soft code", {15'h0000, code_override}, 16'h0000);
    wait_clear();
    chk("soft clear time", 16'(n >= 196 && n <= 202), 16'h0001);
    rd(8'h0D, 16'h0000);
    $display("code and soft reset done");
    // Frame check error only counts when enabled
    frame(8'h00, 1'b1);
    cyc(4);
    rd(8'h0B, 16'h0000);
    wr(8'h03, 16'h0008);
    frame(8'h00, 1'b1);
    cyc(4);
    rd(8'h0B, 16'h0020);
    chk("frame alarm", {15'h0000, alarm_n}, 16'h0000);
    wr(8'h0B, 16'h007F);
    // Watchdog kept alive by kicks, then starved
    wr(8'h03, 16'h0001);
    repeat (4)
    begin
      cyc(30);
      frame(8'h10, 1'b0);
    end
    rd(8'h0B, 16'h0000);
    cyc(60);
    rd(8'h0B, 16'h0040);
    chk("wdog alarm", {15'h0000, alarm_n}, 16'h0000);
    wr(8'h03, 16'h0000);
    rd(8'h0B, 16'h0000);
    wr(8'h03, 16'h0007);
    cyc(65);
    rd(8'h0B, 16'h0000);
    cyc(20);
    rd(8'h0B, 16'h0040);
    wr(8'h03, 16'h0020);
    cyc(1);
    chk("vout hiz", {15'h0000, vout_hiz}, 16'h0001);
    $display("frame check and watchdog done");
    // Power-good follows the enabled arms
    conv_en <= 4'h1;
    pos_en <= 4'h1;
    pos_ok <= 4'h1;
    cyc(6);
    rd(8'h0B, 16'h0100);
    neg_en <= 4'h1;
    cyc(6);
    rd(8'h0B, 16'h0000);
    neg_ok <= 4'h1;
    ald <= 1'b1;
    cyc(6);
    rd(8'h0B, 16'h1100);
    $display("power good done");
    wrap_up();
  end
endmodule
`default_nettype wire
